// ==== tpc_port_config_registers.sv ====
// serial-port register bank of the type-c port controller
//
// Overview of operation
// - pull-up enable bits 7/6 source host current onto line 2/line 1.
// - bits 5/4 close the cable power switch onto line 2/line 1.
// - bit 3 routes measurement to line 2; host must set power field 0x07.
// - bits 1/0 enable sink pull-down termination for line 2/line 1.
// - identity register read-only: version code bits 7:3, revision bits 2:0.
// - current level 00 off, 01 default, 10 medium, 11 high.
`include "tpc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tpc_port_config_registers #(
  // arbitrary identity values
  parameter logic [4:0] VERSION_CODE = 5'h0A,
  parameter logic [2:0] REVISION_CODE = 3'h1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // serial port pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output var logic sdaDriveN,
  // line switch controls
  output logic cc2SourceCurrentEnable,
  output logic cc1SourceCurrentEnable,
  output logic [1:0] sourceCurrentLevel,
  output logic [1:0] cc2SourceCurrent,
  output logic [1:0] cc1SourceCurrent,
  output logic cablePowerToLine2,
  output logic cablePowerToLine1,
  output logic line2MeasureRoute,
  output logic line1MeasureRoute,
  output logic line2SinkTermination,
  output logic line1SinkTermination,
  // measurement, detection and power
  output logic busVoltageMeasureSelect,
  output logic [5:0] measureLevel,
  output logic [5:0] pdDetectThreshold,
  output logic interruptsMasked,
  output logic [7:0] eventMask,
  output logic [3:0] powerStateField,
  output logic measurePowered,
  output var logic softReset,
  // status from the analog side
  input wire logic [7:0] portStatusIn,
  input wire logic [7:0] portFaultIn,
  input wire logic [7:0] eventSet,
  output var logic [7:0] eventFlags
);
  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  logic sclLvl;
  logic sdaLvl;
  logic sclPrev;
  logic sdaPrev;

  tpc_input_sync #(.RESET_VAL(1'b1)) sclSync (
    .clock(clock),
    .reset(reset),
    .pinIn(sclIn),
    .level(sclLvl)
  );
  tpc_input_sync #(.RESET_VAL(1'b1)) sdaSync (
    .clock(clock),
    .reset(reset),
    .pinIn(sdaIn),
    .level(sdaLvl)
  );

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclLvl;
      sdaPrev <= sdaLvl;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign sclRise = sclLvl & ~sclPrev;
  assign sclFall = ~sclLvl & sclPrev;
  assign startCond = sclLvl & sclPrev & sdaPrev & ~sdaLvl;
  assign stopCond = sclLvl & sclPrev & ~sdaPrev & sdaLvl;
  // open drain: only ever pulls low
  assign sdaOut = 1'b0;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] ccSwitch;
  logic [7:0] measureCtl;
  logic [7:0] pdThresh;
  logic [7:0] hostCur;
  logic [7:0] power;
  logic [7:0] statusReg;
  logic [7:0] faultReg;
  logic [7:0] readValue;
  logic wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic rdStrobe;
  logic [7:0] rdAddr;
  logic [7:0] ptr;
  logic [7:0] shiftReg;

  // blank bits and unmapped offsets read as zero
  always_comb begin
    if (ptr == `TPC_ADDR_IDENTITY) begin
      readValue = {VERSION_CODE, REVISION_CODE};
    end else if (ptr == `TPC_ADDR_CC_SWITCH) begin
      readValue = ccSwitch;
    end else if (ptr == `TPC_ADDR_MEASURE) begin
      readValue = measureCtl;
    end else if (ptr == `TPC_ADDR_PD_THRESH) begin
      readValue = pdThresh;
    end else if (ptr == `TPC_ADDR_SOURCE_CURRENT_LEVEL) begin
      readValue = hostCur;
    end else if (ptr == `TPC_ADDR_EVENT_MASK) begin
      readValue = eventMask;
    end else if (ptr == `TPC_ADDR_POWER) begin
      readValue = power;
    end else if (ptr == `TPC_ADDR_STATUS) begin
      readValue = statusReg;
    end else if (ptr == `TPC_ADDR_FAULT) begin
      readValue = faultReg;
    end else if (ptr == `TPC_ADDR_EVENTS) begin
      readValue = eventFlags;
    end else begin
      readValue = 8'h00;
    end
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  tpc_pkg::tpc_state_t state;
  logic [3:0] bitCnt;
  logic havePtr;
  logic readMode;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= tpc_pkg::ST_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      ptr <= 8'h00;
      havePtr <= 1'b0;
      readMode <= 1'b0;
      sdaDriveN <= 1'b1;
      wrStrobe <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
      rdStrobe <= 1'b0;
      rdAddr <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      if (startCond) begin
        state <= tpc_pkg::ST_ADDR;
        bitCnt <= 4'h0;
        havePtr <= 1'b0;
        sdaDriveN <= 1'b1;
      end else if (stopCond) begin
        state <= tpc_pkg::ST_IDLE;
        sdaDriveN <= 1'b1;
      end else begin
        case (state)
          tpc_pkg::ST_ADDR, tpc_pkg::ST_WBYTE: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaLvl};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              if (state == tpc_pkg::ST_ADDR) begin
                if (shiftReg[7:1] == `TPC_SLAVE_ADDR) begin
                  readMode <= shiftReg[0];
                  sdaDriveN <= 1'b0;
                  state <= tpc_pkg::ST_ACK_ADDR;
                end else begin
                  state <= tpc_pkg::ST_IDLE;
                end
              end else begin
                // first byte of a write sets the pointer, the rest store
                if (!havePtr) begin
                  ptr <= shiftReg;
                  havePtr <= 1'b1;
                end else begin
                  wrStrobe <= 1'b1;
                  wrAddr <= ptr;
                  wrData <= shiftReg;
                  ptr <= ptr + 8'h01;
                end
                sdaDriveN <= 1'b0;
                state <= tpc_pkg::ST_ACK_W;
              end
            end
          end
          tpc_pkg::ST_ACK_ADDR, tpc_pkg::ST_ACK_W, tpc_pkg::ST_ACK_R: begin
            if (state == tpc_pkg::ST_ACK_R && sclRise && sdaLvl) begin
              // not acknowledged: master ends the read
              state <= tpc_pkg::ST_IDLE;
            end else if (sclFall) begin
              bitCnt <= 4'h0;
              if (state != tpc_pkg::ST_ACK_W && (readMode || state == tpc_pkg::ST_ACK_R)) begin
                shiftReg <= readValue;
                sdaDriveN <= readValue[7];
                rdStrobe <= 1'b1;
                rdAddr <= ptr;
                ptr <= ptr + 8'h01;
                state <= tpc_pkg::ST_RBYTE;
              end else begin
                sdaDriveN <= 1'b1;
                state <= tpc_pkg::ST_WBYTE;
              end
            end
          end
          tpc_pkg::ST_RBYTE: begin
            if (sclFall) begin
              if (bitCnt == 4'h7) begin
                sdaDriveN <= 1'b1;
                state <= tpc_pkg::ST_ACK_R;
              end else begin
                shiftReg <= {shiftReg[6:0], 1'b0};
                sdaDriveN <= shiftReg[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          default: begin
            sdaDriveN <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // writes to read-only, reserved or unmapped offsets are dropped
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ccSwitch <= `TPC_RST_CC_SWITCH;
      measureCtl <= `TPC_RST_MEASURE;
      pdThresh <= `TPC_RST_PD_THRESH;
      hostCur <= `TPC_RST_SOURCE_CURRENT_LEVEL;
      eventMask <= `TPC_RST_EVENT_MASK;
      power <= `TPC_RST_POWER;
    end else if (softReset) begin
      ccSwitch <= `TPC_RST_CC_SWITCH;
      measureCtl <= `TPC_RST_MEASURE;
      pdThresh <= `TPC_RST_PD_THRESH;
      hostCur <= `TPC_RST_SOURCE_CURRENT_LEVEL;
      eventMask <= `TPC_RST_EVENT_MASK;
      power <= `TPC_RST_POWER;
    end else if (wrStrobe) begin
      if (wrAddr == `TPC_ADDR_CC_SWITCH) begin
        ccSwitch <= wrData;
      end else if (wrAddr == `TPC_ADDR_MEASURE) begin
        measureCtl <= wrData & `TPC_WMASK_MEASURE;
      end else if (wrAddr == `TPC_ADDR_PD_THRESH) begin
        pdThresh <= wrData & `TPC_WMASK_PD_THRESH;
      end else if (wrAddr == `TPC_ADDR_SOURCE_CURRENT_LEVEL) begin
        hostCur <= wrData & `TPC_WMASK_SOURCE_CURRENT_LEVEL;
      end else if (wrAddr == `TPC_ADDR_EVENT_MASK) begin
        eventMask <= wrData;
      end else if (wrAddr == `TPC_ADDR_POWER) begin
        power <= wrData & `TPC_WMASK_POWER;
      end
    end
  end

  // soft reset self-clears after one cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      softReset <= 1'b0;
    end else begin
      softReset <= wrStrobe && wrAddr == `TPC_ADDR_SOFT_RESET && wrData[`TPC_BIT_SOFT_RESET];
    end
  end

  // ----------------------------------------
  // status and event flags
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      statusReg <= `TPC_RST_STATUS;
      faultReg <= `TPC_RST_FAULT;
    end else begin
      statusReg <= portStatusIn;
      faultReg <= portFaultIn;
    end
  end

  // read clears; a new event in the clearing cycle survives
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      eventFlags <= `TPC_RST_EVENTS;
    end else if (softReset) begin
      eventFlags <= `TPC_RST_EVENTS | eventSet;
    end else if (rdStrobe && rdAddr == `TPC_ADDR_EVENTS) begin
      eventFlags <= eventSet;
    end else begin
      eventFlags <= eventFlags | eventSet;
    end
  end

  // ----------------------------------------
  // switch and control outputs
  // ----------------------------------------
  // pull-up current per line
  assign cc2SourceCurrentEnable = ccSwitch[`TPC_BIT_CC2_PULLUP];
  assign cc1SourceCurrentEnable = ccSwitch[`TPC_BIT_CC1_PULLUP];
  // level gated by each line's enable
  assign sourceCurrentLevel = hostCur[3:2];
  assign cc2SourceCurrent = cc2SourceCurrentEnable ? sourceCurrentLevel : 2'b00;
  assign cc1SourceCurrent = cc1SourceCurrentEnable ? sourceCurrentLevel : 2'b00;
  assign cablePowerToLine2 = ccSwitch[`TPC_BIT_CC2_VCONN];
  assign cablePowerToLine1 = ccSwitch[`TPC_BIT_CC1_VCONN];
  assign line2MeasureRoute = ccSwitch[`TPC_BIT_CC2_MEAS];
  assign line1MeasureRoute = ccSwitch[`TPC_BIT_CC1_MEAS];
  assign line2SinkTermination = ccSwitch[`TPC_BIT_CC2_PDWN];
  assign line1SinkTermination = ccSwitch[`TPC_BIT_CC1_PDWN];
  // measure path only valid in power state 0x07
  assign measurePowered = power[3:0] == `TPC_POWER_MEASURE;
  assign busVoltageMeasureSelect = measureCtl[`TPC_BIT_VBUS_MEAS];
  assign measureLevel = measureCtl[5:0];
  assign pdDetectThreshold = pdThresh[5:0];
  assign interruptsMasked = hostCur[`TPC_BIT_INT_MASK];
  assign powerStateField = power[3:0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence swWrite;
    wrStrobe && wrAddr == `TPC_ADDR_CC_SWITCH && !softReset;
  endsequence
  sequence curWriteThenEnabled;
    wrStrobe && wrAddr == `TPC_ADDR_SOURCE_CURRENT_LEVEL && !softReset ##1 cc1SourceCurrentEnable;
  endsequence
  sequence powerWrite;
    wrStrobe && wrAddr == `TPC_ADDR_POWER && !softReset;
  endsequence

  pullup_follows_write_a: assert property (swWrite |=>
    {cc2SourceCurrentEnable, cc1SourceCurrentEnable} == $past(wrData[7:6]))
    else $error("pull-up enables do not follow written value");
  vconn_follows_write_a: assert property (swWrite |=>
    {cablePowerToLine2, cablePowerToLine1} == $past(wrData[5:4]))
    else $error("cable power switches do not follow written value");
  meas2_route_a: assert property (swWrite |=>
    line2MeasureRoute == $past(wrData[3]))
    else $error("line 2 measure route wrong");
  power_state_a: assert property (powerWrite |=>
    powerStateField == $past(wrData[3:0])
    && measurePowered == ($past(wrData[3:0]) == `TPC_POWER_MEASURE))
    else $error("power field or measure power flag wrong");
  meas1_route_a: assert property (swWrite |=>
    line1MeasureRoute == $past(wrData[2]))
    else $error("line 1 measure route wrong");
  sink_term_write_a: assert property (swWrite |=>
    {line2SinkTermination, line1SinkTermination} == $past(wrData[1:0]))
    else $error("sink terminations do not follow written value");
  identity_read_a: assert property (rdStrobe && rdAddr == `TPC_ADDR_IDENTITY |->
    shiftReg == {VERSION_CODE, REVISION_CODE})
    else $error("identity read returned wrong value");
  switch_reset_a: assert property ($past(reset) |-> ccSwitch == `TPC_RST_CC_SWITCH)
    else $error("switch register not at reset value");
  current_level_a: assert property (curWriteThenEnabled |->
    cc1SourceCurrent == $past(wrData[3:2]))
    else $error("line 1 current level does not follow selection");
endmodule
`default_nettype wire

// ==== tpc_map.svh ====
// register map, field positions and reset values of the port config bank
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// ----------------------------------------
// serial port
// ----------------------------------------
`define TPC_SLAVE_ADDR 7'h22

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TPC_ADDR_IDENTITY 8'h01
`define TPC_ADDR_CC_SWITCH 8'h02
`define TPC_ADDR_MEASURE 8'h04
`define TPC_ADDR_PD_THRESH 8'h05
`define TPC_ADDR_SOURCE_CURRENT_LEVEL 8'h06
`define TPC_ADDR_EVENT_MASK 8'h0A
`define TPC_ADDR_POWER 8'h0B
`define TPC_ADDR_SOFT_RESET 8'h0C
`define TPC_ADDR_STATUS 8'h40
`define TPC_ADDR_FAULT 8'h41
`define TPC_ADDR_EVENTS 8'h42

// ----------------------------------------
// reset values
// ----------------------------------------
`define TPC_RST_CC_SWITCH 8'h03
`define TPC_RST_MEASURE 8'h00
`define TPC_RST_PD_THRESH 8'h20
`define TPC_RST_SOURCE_CURRENT_LEVEL 8'h20
`define TPC_RST_EVENT_MASK 8'h00
`define TPC_RST_POWER 8'h0F
`define TPC_RST_STATUS 8'h27
`define TPC_RST_FAULT 8'h28
`define TPC_RST_EVENTS 8'h25

// ----------------------------------------
// writable bits and fields
// ----------------------------------------
`define TPC_WMASK_MEASURE 8'h7F
`define TPC_WMASK_PD_THRESH 8'h3F
`define TPC_WMASK_SOURCE_CURRENT_LEVEL 8'h2C
`define TPC_WMASK_POWER 8'h0F
`define TPC_BIT_CC2_PULLUP 7
`define TPC_BIT_CC1_PULLUP 6
`define TPC_BIT_CC2_VCONN 5
`define TPC_BIT_CC1_VCONN 4
`define TPC_BIT_CC2_MEAS 3
`define TPC_BIT_CC1_MEAS 2
`define TPC_BIT_CC2_PDWN 1
`define TPC_BIT_CC1_PDWN 0
`define TPC_BIT_VBUS_MEAS 6
`define TPC_BIT_INT_MASK 5
`define TPC_BIT_SOFT_RESET 0
`define TPC_POWER_MEASURE 4'h7

`endif

// ==== tpc_pkg.sv ====
// types shared by the port config bank
package tpc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WBYTE,
    ST_ACK_W,
    ST_RBYTE,
    ST_ACK_R
  } tpc_state_t;
endpackage

// ==== tpc_input_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module tpc_input_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // pin and filtered level
  input wire logic pinIn,
  output var logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // stage1 is never looked at here, only stages two and three
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      level <= RESET_VAL;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule
`default_nettype wire

// ==== tpc_host_model.sv ====
// host-side serial master model that reaches the port config bank
`include "tpc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tpc_host_model #(
  parameter int HALF = 10
) (
  // clock
  input wire logic clock,
  // serial bus
  input wire logic sdaLine,
  output var logic sclPin,
  output var logic sdaLow
);
  // ----------------------------------------
  // bit level
  // ----------------------------------------
  initial begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // doubles as repeated start: data released before clock rises
  task automatic start_cond();
    sdaLow = 1'b0;
    tick(HALF);
    sclPin = 1'b1;
    tick(HALF);
    sdaLow = 1'b1;
    tick(HALF);
    sclPin = 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sdaLow = 1'b1;
    tick(HALF);
    sclPin = 1'b1;
    tick(HALF);
    sdaLow = 1'b0;
    tick(HALF);
  endtask
  // data changes only two clocks after scl falls, never with it
  task automatic bit_out(input logic b);
    sdaLow = ~b;
    tick(HALF);
    sclPin = 1'b1;
    tick(HALF);
    sclPin = 1'b0;
    tick(2);
  endtask
  task automatic bit_in(output logic b);
    sdaLow = 1'b0;
    tick(HALF);
    sclPin = 1'b1;
    tick(HALF / 2);
    b = sdaLine;
    tick(HALF / 2);
    sclPin = 1'b0;
    tick(2);
  endtask
  // ----------------------------------------
  // byte and register level
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(nack);
  endtask
  task automatic recv_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(last);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                           input logic [7:0] data, output logic acked);
    logic n1, n2, n3;
    start_cond();
    send_byte({dev, 1'b0}, n1);
    send_byte(addr, n2);
    send_byte(data, n3);
    stop_cond();
    acked = ~(n1 | n2 | n3);
  endtask
  // whole byte returned, caller compares all eight bits
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    logic n;
    start_cond();
    send_byte({`TPC_SLAVE_ADDR, 1'b0}, n);
    send_byte(addr, n);
    start_cond();
    send_byte({`TPC_SLAVE_ADDR, 1'b1}, n);
    recv_byte(data, 1'b1);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the port config register bank
`include "tpc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock, reset, sclPin, sdaLow, sdaOut, sdaDriveN;
  logic cc2En, cc1En, vc2, vc1, ms2, ms1, pd2, pd1;
  logic [1:0] level, cur2, cur1;
  logic busSel, intMasked, measPowered, softReset;
  logic [5:0] measLevel, pdThresh;
  logic [7:0] evMask, evFlags, portStatusIn, portFaultIn, eventSet;
  logic [3:0] powerField;
  int nErrors = 0;
  int nTests = 0;
  wire logic [7:0] swOut = {cc2En, cc1En, vc2, vc1, ms2, ms1, pd2, pd1};
  // open-drain bus with pull-up
  wire logic sdaLine = ~sdaLow & (sdaDriveN | sdaOut);
  // ----------------------------------------
  // instances
  // ----------------------------------------
  // arbitrary identity values
  tpc_port_config_registers #(.VERSION_CODE(5'h13), .REVISION_CODE(3'h5))
    u_tpc_port_config_registers (
    .clock(clock), .reset(reset), .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaDriveN(sdaDriveN), .cc2SourceCurrentEnable(cc2En), .cc1SourceCurrentEnable(cc1En),
    .sourceCurrentLevel(level), .cc2SourceCurrent(cur2), .cc1SourceCurrent(cur1),
    .cablePowerToLine2(vc2), .cablePowerToLine1(vc1), .line2MeasureRoute(ms2),
    .line1MeasureRoute(ms1), .line2SinkTermination(pd2), .line1SinkTermination(pd1),
    .busVoltageMeasureSelect(busSel), .measureLevel(measLevel), .pdDetectThreshold(pdThresh),
    .interruptsMasked(intMasked), .eventMask(evMask), .powerStateField(powerField),
    .measurePowered(measPowered), .softReset(softReset), .portStatusIn(portStatusIn),
    .portFaultIn(portFaultIn), .eventSet(eventSet), .eventFlags(evFlags));
  tpc_host_model u_tpc_host_model (
    .clock(clock), .sdaLine(sdaLine), .sclPin(sclPin), .sdaLow(sdaLow));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  int nSoft = 0;
  // soft reset strobe counted away from its launching edge
  always @(negedge clock) begin
    if (softReset === 1'b1) begin
      nSoft++;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic acked;
    u_tpc_host_model.write_reg(`TPC_SLAVE_ADDR, addr, data, acked);
    check({7'h00, acked}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_tpc_host_model.read_reg(addr, d);
    check(d, exp);
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // a full run is about 37k clocks
  initial begin
    repeat (100000) @(posedge clock);
    nErrors++;
    report_and_stop();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [7:0] addrs [9] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B, 8'h40, 8'h41, 8'h42};
    logic [7:0] rsts [9] = '{8'h03, 8'h00, 8'h20, 8'h20, 8'h00, 8'h0F, 8'h27, 8'h28, 8'h25};
    logic ack;
    reset = 1'b1;
    portStatusIn = 8'h27;
    portFaultIn = 8'h28;
    eventSet = 8'h00;
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    u_tpc_host_model.tick(10);
    check(swOut, 8'h03);
    check({intMasked, measPowered, measLevel}, 8'h80);
    check({2'b00, pdThresh}, 8'h20);
    check({4'h0, powerField}, 8'h0F);
    check(evMask, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rd(addrs[i], rsts[i]);
    end
    rd(8'h01, {5'h13, 3'h5});
    wr(8'h01, 8'hFF);
    rd(8'h01, {5'h13, 3'h5});
    // measure power state set before any route bit
    wr(8'h0B, 8'h07);
    check({4'h0, powerField}, 8'h07);
    // each switch bit alone, back to back
    for (int i = 0; i < 8; i++) begin
      wr(8'h02, 8'h01 << i);
      rd(8'h02, 8'h01 << i);
      check(swOut, 8'h01 << i);
    end
    wr(8'h02, 8'hC0);
    for (int lv = 0; lv < 4; lv++) begin
      wr(8'h06, {4'h2, lv[1:0], 2'b00});
      check({1'b0, intMasked, cur2, cur1, level}, {2'b01, lv[1:0], lv[1:0], lv[1:0]});
    end
    wr(8'h02, 8'h80);
    check({4'h0, cur2, cur1}, 8'h0C);
    wr(8'h02, 8'h0C);
    check({5'h00, measPowered, ms2, ms1}, 8'h07);
    // routes cleared before bus voltage select
    wr(8'h02, 8'h00);
    wr(8'h04, 8'h40);
    check({1'b0, busSel, measLevel}, 8'h40);
    rd(8'h04, 8'h40);
    wr(8'h05, 8'h00);
    check({2'b00, pdThresh}, 8'h00);
    wr(8'h0A, 8'h81);
    check(evMask, 8'h81);
    rd(8'h42, 8'h00);
    @(posedge clock);
    #1 eventSet = 8'h81;
    @(posedge clock);
    #1 eventSet = 8'h00;
    rd(8'h42, 8'h81);
    wr(8'h02, 8'hF0);
    wr(8'h0C, 8'h01);
    check(nSoft[7:0], 8'h01);
    rd(8'h02, 8'h03);
    check(swOut, 8'h03);
    check({4'h0, powerField}, 8'h0F);
    check(evMask, 8'h00);
    rd(8'h42, 8'h25);
    // another target address is ignored and never acknowledged
    u_tpc_host_model.write_reg(7'h23, 8'h02, 8'hC0, ack);
    check({7'h00, ack}, 8'h00);
    check(swOut, 8'h03);
    report_and_stop();
  end
endmodule
`default_nettype wire
